// File: inc/sleep_wake_pkg.sv
/*
 constants and state types of the sleep and wake controller.
 assumes a 10 MHz system clock and one oscillator period per clock.
*/
package sleep_wake_pkg;
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_WDT_COUNT = 4'hC;
   localparam int CTRL_SOFT_EN_BIT = 0;
   localparam int CTRL_SEL_LSB = 1;
   localparam int CTRL_SEL_W = 4;
   localparam int CTRL_W = 5;
   localparam logic [4:0] CONTROL_RESET = 5'h08;
   localparam logic [3:0] WDT_SEL_MAX = 4'hB;
   localparam int ST_PD_BIT = 0;
   localparam int ST_TO_BIT = 1;
   localparam int ST_ASLEEP_BIT = 2;
   localparam int ST_SETTLE_BIT = 3;
   localparam int ST_WDT_RUN_BIT = 4;
   localparam int ST_CAUSE_LSB = 5;
   localparam int IRQ_SECOND_TIMER = 0;
   localparam int IRQ_CAPTURE = 1;
   localparam int IRQ_ADC = 2;
   localparam int IRQ_EEPROM = 3;
   localparam int IRQ_COMPARATOR = 4;
   localparam int IRQ_CHANGE = 5;
   localparam int IRQ_EXT_PIN = 6;
   localparam int IRQ_COUNT = 7;
   localparam logic [6:0] IRQ_ENABLE_RESET = 7'h00;
   localparam logic [1:0] CAUSE_NONE = 2'h0;
   localparam logic [1:0] CAUSE_WDT = 2'h1;
   localparam logic [1:0] CAUSE_IRQ = 2'h2;
   localparam logic [1:0] CAUSE_MASTER_CLEAR_PIN = 2'h3;
   localparam logic [12:0] VECTOR_ADDR = 13'h0004;
   localparam int CLK_PERIOD_NS = 100;
   localparam int OSC_PERIOD_NS = 100;
   localparam int OST_OSC_PERIODS = 1024;
   localparam int OST_CYCLES =
      (OST_OSC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [10:0] OST_LAST = 11'(OST_CYCLES - 1);
   typedef enum logic [1:0] {
      st_run,
      st_sleep,
      st_settle
   } power_state_t;
   typedef enum logic [2:0] {
      low_power_crystal_mode,
      crystal_mode,
      fast_crystal_mode,
      external_clock_mode,
      on_chip_oscillator_mode,
      resistor_cap_mode
   } osc_mode_t;
endpackage

// File: logic/sleep_wake_controller.sv
/*
 sleep entry, wake detection, watchdog and oscillator settle control for a
 small 8-bit core, with an avalon-mm register slave.
 assumes the core pulses sleep_op and watchdog_clear_op for one cycle, and
 that irq_flag and master_clear_pin_n are asynchronous to clk_sys.
*/
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
// Summary of operation
// - sleep with watchdog on clears its count; it keeps counting in sleep.
// - entering sleep clears power_down_flag and sets timeout_flag.
// - oscillator driver is off during sleep; no core clock until wake.
// - port pins hold their pre-sleep drive state during sleep.
// - master clear wake performs a full device reset.
// - watchdog or enabled interrupt wake resumes execution.
// - watchdog wake clears timeout_flag.
// - power_down_flag set at power-up, cleared only by an executed sleep.
// - seven named peripheral interrupts can wake the device.
// - second_timer wakes only asynchronous; adc only on private oscillator.
// - clock-dependent peripherals raise nothing in sleep; their clock stops.
// - during sleep execution the next instruction is prefetched.
// - only individually enabled sources wake; global enable does not gate.
// - interrupt wake with global enable clear continues in line.
// - interrupt wake with global enable set vectors to 0004h afterwards.
// - every wake clears the watchdog count.
// - enabled interrupt pending at sleep makes sleep a no-op.
// - interrupt during or after sleep: sleep completes, then immediate wake.
// - crystal modes wait 1024 oscillator periods on watchdog or interrupt wake; others skip it.
// - watchdog runs when fuse set; else software enable controls it.
// - in crystal modes watchdog is held cleared until settle ends.
module sleep_wake_controller #(
   parameter int PORT_W = 8,
   parameter int WDT_BASE_CYCLES = 32
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic sleep_op,
   input wire logic watchdog_clear_op,
   input wire logic global_irq_enable,
   input wire logic watchdog_fuse_enable,
   input wire logic [2:0] osc_mode,
   input wire logic second_timer_async,
   input wire logic adc_private_osc_sel,
   input wire logic [6:0] irq_flag,
   input wire logic master_clear_pin_n,
   input wire logic [PORT_W-1:0] port_out_core,
   input wire logic [PORT_W-1:0] port_oe_core,
   output logic [PORT_W-1:0] port_out,
   output logic [PORT_W-1:0] port_oe,
   output logic osc_driver_en,
   output logic core_clock_en,
   output logic periph_clock_en,
   output logic core_reset,
   output logic resume,
   output logic vector_request,
   output logic [12:0] vector_addr,
   output logic prefetch_next,
   output logic power_down_flag,
   output logic timeout_flag,
   output logic watchdog_timeout
);
   localparam int SYNC_W = sleep_wake_pkg::IRQ_COUNT + 1;
   localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b1, {(SYNC_W-1){1'b0}}};

   initial begin
      if (PORT_W < 1 || WDT_BASE_CYCLES < 1 ||
         WDT_BASE_CYCLES > 32768) begin
         $error("sleep_wake_controller: unsupported parameter value");
      end
   end

   function automatic logic crystal(input logic [2:0] mode);
      crystal = (mode == 3'(sleep_wake_pkg::low_power_crystal_mode)) ||
         (mode == 3'(sleep_wake_pkg::crystal_mode)) ||
         (mode == 3'(sleep_wake_pkg::fast_crystal_mode));
   endfunction

   // three-flop input synchronisers; filtered value moves when flops 2 and 3 agree
   logic [SYNC_W-1:0] sync_1, sync_2, sync_3, sync_filt;
   logic [SYNC_W-1:0] next_sync_filt;
   logic [SYNC_W-1:0] async_in;
   assign async_in = {master_clear_pin_n, irq_flag};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
         always_comb begin
            next_sync_filt[gi] = (sync_2[gi] == sync_3[gi]) ? sync_3[gi] :
               sync_filt[gi];
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sync_1 <= SYNC_IDLE;
         sync_2 <= SYNC_IDLE;
         sync_3 <= SYNC_IDLE;
         sync_filt <= SYNC_IDLE;
      end else if (clk_en) begin
         sync_1 <= async_in;
         sync_2 <= sync_1;
         sync_3 <= sync_2;
         sync_filt <= next_sync_filt;
      end
   end

   logic [6:0] irq_now;
   logic master_clear_pin_active;
   assign irq_now = sync_filt[sleep_wake_pkg::IRQ_COUNT-1:0];
   assign master_clear_pin_active = !sync_filt[sleep_wake_pkg::IRQ_COUNT];

   // register slave
   logic bus_ack, next_bus_ack;
   logic [31:0] rdata, next_rdata;
   logic [4:0] control, next_control;
   logic [6:0] irq_enable, next_irq_enable;
   sleep_wake_pkg::power_state_t state, next_state;
   logic [1:0] cause, next_cause;
   logic [31:0] wdt_count, next_wdt_count;
   logic wdt_on;
   logic [3:0] sel_eff;

   assign wdt_on = watchdog_fuse_enable ||
      control[sleep_wake_pkg::CTRL_SOFT_EN_BIT];
   assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
   assign avs_readdata = rdata;

   always_comb begin
      next_bus_ack = (avs_read || avs_write) && !bus_ack;
      next_rdata = rdata;
      next_control = control;
      next_irq_enable = irq_enable;
      if (avs_read && !bus_ack) begin
         next_rdata = 32'h0000_0000;
         case (avs_address)
            sleep_wake_pkg::ADDR_CONTROL: begin
               next_rdata[sleep_wake_pkg::CTRL_W-1:0] =
                  control;
            end
            sleep_wake_pkg::ADDR_IRQ_ENABLE: begin
               next_rdata[sleep_wake_pkg::IRQ_COUNT-1:0] =
                  irq_enable;
            end
            sleep_wake_pkg::ADDR_STATUS: begin
               next_rdata[sleep_wake_pkg::ST_PD_BIT] = power_down_flag;
               next_rdata[sleep_wake_pkg::ST_TO_BIT] = timeout_flag;
               next_rdata[sleep_wake_pkg::ST_ASLEEP_BIT] =
                  (state == sleep_wake_pkg::st_sleep);
               next_rdata[sleep_wake_pkg::ST_SETTLE_BIT] =
                  (state == sleep_wake_pkg::st_settle);
               next_rdata[sleep_wake_pkg::ST_WDT_RUN_BIT] =
                  wdt_on;
               next_rdata[sleep_wake_pkg::ST_CAUSE_LSB +: 2] =
                  cause;
            end
            sleep_wake_pkg::ADDR_WDT_COUNT: begin
               next_rdata = wdt_count;
            end
            default: begin
               next_rdata = 32'h0000_0000;
            end
         endcase
      end
      // writes land on the edge where waitrequest is low
      if (avs_write && bus_ack && avs_byteenable[0]) begin
         case (avs_address)
            sleep_wake_pkg::ADDR_CONTROL: begin
               next_control =
                  avs_writedata[sleep_wake_pkg::CTRL_W-1:0];
            end
            sleep_wake_pkg::ADDR_IRQ_ENABLE: begin
               next_irq_enable =
                  avs_writedata[sleep_wake_pkg::IRQ_COUNT-1:0];
            end
            default: begin
               next_control = control;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         bus_ack <= 1'b0;
         rdata <= 32'h0000_0000;
         control <= sleep_wake_pkg::CONTROL_RESET;
         irq_enable <= sleep_wake_pkg::IRQ_ENABLE_RESET;
      end else if (clk_en) begin
         bus_ack <= next_bus_ack;
         rdata <= next_rdata;
         control <= next_control;
         irq_enable <= next_irq_enable;
      end
   end

   // wake qualification
   logic [6:0] sleep_qual;
   logic pending_run, pending_sleep;
   always_comb begin
      sleep_qual = 7'h7F;
      sleep_qual[sleep_wake_pkg::IRQ_SECOND_TIMER] =
         second_timer_async;
      sleep_qual[sleep_wake_pkg::IRQ_ADC] = adc_private_osc_sel;
   end
   // global enable deliberately absent from both terms
   assign pending_run = |(irq_now & irq_enable);
   assign pending_sleep =
      |(irq_now & irq_enable & sleep_qual);

   // watchdog period: base shifted by select, reserved selects clamp to longest
   logic [31:0] wdt_last;
   assign sel_eff = (control[sleep_wake_pkg::CTRL_SEL_LSB +: sleep_wake_pkg::CTRL_SEL_W] >
      sleep_wake_pkg::WDT_SEL_MAX) ? sleep_wake_pkg::WDT_SEL_MAX :
      control[sleep_wake_pkg::CTRL_SEL_LSB +: sleep_wake_pkg::CTRL_SEL_W];
   assign wdt_last =
      (32'(WDT_BASE_CYCLES) << sel_eff) - 32'h0000_0001;

   // power state machine
   logic next_pd, next_to;
   logic [10:0] ost_count, next_ost_count;
   logic vec_pend, next_vec_pend;
   logic next_resume, next_vector_request, next_prefetch, next_wdt_timeout;
   logic next_wdt_reset, wdt_reset;
   logic [PORT_W-1:0] next_port_out, next_port_oe;
   logic wdt_expire;

   assign wdt_expire = wdt_on && (state != sleep_wake_pkg::st_settle) &&
      (wdt_count == wdt_last);

   always_comb begin
      next_state = state;
      next_pd = power_down_flag;
      next_to = timeout_flag;
      next_cause = cause;
      next_ost_count = ost_count;
      next_vec_pend = vec_pend;
      next_resume = 1'b0;
      next_vector_request = 1'b0;
      next_prefetch = 1'b0;
      next_wdt_timeout = 1'b0;
      next_wdt_reset = 1'b0;
      next_port_out = port_out;
      next_port_oe = port_oe;
      // watchdog keeps counting in sleep; cleared on expiry
      if (wdt_on && !wdt_expire &&
         state != sleep_wake_pkg::st_settle) begin
         next_wdt_count = wdt_count + 32'h0000_0001;
      end else begin
         next_wdt_count = 32'h0000_0000;
      end
      if (wdt_expire) begin
         next_wdt_timeout = 1'b1;
      end
      case (state)
         sleep_wake_pkg::st_run: begin
            next_port_out = port_out_core;
            next_port_oe = port_oe_core;
            if (master_clear_pin_active) begin
               next_cause = sleep_wake_pkg::CAUSE_NONE;
            end else if (wdt_expire) begin
               next_wdt_reset = 1'b1;
               next_to = 1'b0;
            end else if (sleep_op) begin
               next_prefetch = 1'b1;
               if (!pending_run) begin
                  next_wdt_count = 32'h0000_0000;
                  next_pd = 1'b0;
                  next_to = 1'b1;
                  next_state = sleep_wake_pkg::st_sleep;
               end
            end else if (watchdog_clear_op) begin
               next_wdt_count = 32'h0000_0000;
            end
         end
         sleep_wake_pkg::st_sleep: begin
            // pins frozen at their last awake drive
            next_port_out = port_out;
            next_port_oe = port_oe;
            if (master_clear_pin_active || wdt_expire || pending_sleep) begin
               next_wdt_count = 32'h0000_0000;
               next_vec_pend = 1'b0;
               if (master_clear_pin_active) begin
                  next_cause = sleep_wake_pkg::CAUSE_MASTER_CLEAR_PIN;
                  next_state = sleep_wake_pkg::st_run;
               end else begin
                  if (wdt_expire) begin
                     next_cause = sleep_wake_pkg::CAUSE_WDT;
                     next_to = 1'b0;
                  end else begin
                     next_cause = sleep_wake_pkg::CAUSE_IRQ;
                     next_vec_pend = global_irq_enable;
                  end
                  next_ost_count = 11'h000;
                  if (crystal(osc_mode)) begin
                     next_state = sleep_wake_pkg::st_settle;
                  end else begin
                     next_state = sleep_wake_pkg::st_run;
                     next_resume = 1'b1;
                     next_vector_request =
                        global_irq_enable && !wdt_expire;
                  end
               end
            end
         end
         sleep_wake_pkg::st_settle: begin
            next_wdt_count = 32'h0000_0000;
            if (master_clear_pin_active) begin
               next_cause = sleep_wake_pkg::CAUSE_MASTER_CLEAR_PIN;
               next_state = sleep_wake_pkg::st_run;
            end else if (ost_count == sleep_wake_pkg::OST_LAST) begin
               next_state = sleep_wake_pkg::st_run;
               next_resume = 1'b1;
               next_vector_request = vec_pend;
            end else begin
               next_ost_count = ost_count + 11'h001;
            end
         end
         default: begin
            next_state = sleep_wake_pkg::st_run;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state <= sleep_wake_pkg::st_run;
         power_down_flag <= 1'b1;
         timeout_flag <= 1'b1;
         cause <= sleep_wake_pkg::CAUSE_NONE;
         wdt_count <= 32'h0000_0000;
         ost_count <= 11'h000;
         vec_pend <= 1'b0;
         resume <= 1'b0;
         vector_request <= 1'b0;
         prefetch_next <= 1'b0;
         watchdog_timeout <= 1'b0;
         wdt_reset <= 1'b0;
         port_out <= {PORT_W{1'b0}};
         port_oe <= {PORT_W{1'b0}};
      end else if (clk_en) begin
         state <= next_state;
         power_down_flag <= next_pd;
         timeout_flag <= next_to;
         cause <= next_cause;
         wdt_count <= next_wdt_count;
         ost_count <= next_ost_count;
         vec_pend <= next_vec_pend;
         resume <= next_resume;
         vector_request <= next_vector_request;
         prefetch_next <= next_prefetch;
         watchdog_timeout <= next_wdt_timeout;
         wdt_reset <= next_wdt_reset;
         port_out <= next_port_out;
         port_oe <= next_port_oe;
      end
   end

   // settle keeps the oscillator running but the core clock gated
   assign osc_driver_en = (state != sleep_wake_pkg::st_sleep);
   assign core_clock_en = (state == sleep_wake_pkg::st_run);
   assign periph_clock_en = (state == sleep_wake_pkg::st_run);
   assign core_reset = master_clear_pin_active || wdt_reset;
   assign vector_addr = sleep_wake_pkg::VECTOR_ADDR;
endmodule

// File: verification/sleep_wake_checker.sv
/*
 port-level assertions for sleep_wake_controller.
 assumes one clock domain and a bind onto every controller instance.
*/
`timescale 1ns/1ps
module sleep_wake_checker #(
   parameter int PORT_W = 8,
   parameter int WDT_BASE_CYCLES = 32
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic sleep_op,
   input wire logic master_clear_pin_n,
   input wire logic [PORT_W-1:0] port_out,
   input wire logic [PORT_W-1:0] port_oe,
   input wire logic osc_driver_en,
   input wire logic core_clock_en,
   input wire logic periph_clock_en,
   input wire logic core_reset,
   input wire logic resume,
   input wire logic vector_request,
   input wire logic [12:0] vector_addr,
   input wire logic prefetch_next,
   input wire logic power_down_flag,
   input wire logic timeout_flag,
   input wire logic watchdog_timeout
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   int unsigned settle_cnt;
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !osc_driver_en || core_clock_en) begin
         settle_cnt <= 0;
      end else if (clk_en) begin
         settle_cnt <= settle_cnt + 1;
      end
   end
   property p_bus_ack;
      (avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer late");
   property p_entry_flags;
      $fell(osc_driver_en) |-> !power_down_flag && timeout_flag;
   endproperty
   a_entry_flags: assert property (p_entry_flags) else $error("flags wrong in sleep");
   property p_osc_off;
      !osc_driver_en |-> !core_clock_en && !periph_clock_en;
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("clock runs in sleep");
   property p_port_hold;
      !core_clock_en |=> $stable(port_out) && $stable(port_oe);
   endproperty
   a_port_hold: assert property (p_port_hold) else $error("port moved in sleep");
   property p_prefetch;
      sleep_op && core_clock_en && !core_reset |=> prefetch_next || watchdog_timeout;
   endproperty
   a_prefetch: assert property (p_prefetch) else $error("no prefetch");
   property p_vector;
      vector_request |-> resume && vector_addr == sleep_wake_pkg::VECTOR_ADDR;
   endproperty
   a_vector: assert property (p_vector) else $error("vector wrong");
   property p_master_clear_pin;
      $fell(master_clear_pin_n) |-> ##[2:5] core_reset;
   endproperty
   a_master_clear_pin: assert property (p_master_clear_pin) else $error("master_clear_pin ignored");
   property p_pd_clear;
      $fell(power_down_flag) |-> !osc_driver_en;
   endproperty
   a_pd_clear: assert property (p_pd_clear) else $error("pd cleared awake");
   property p_to_clear;
      $fell(timeout_flag) |-> watchdog_timeout || $past(watchdog_timeout);
   endproperty
   a_to_clear: assert property (p_to_clear) else $error("to cleared early");
   // master_clear_pin may cut settle short, so it is left out
   property p_settle;
      $rose(core_clock_en) && !core_reset && settle_cnt != 0 |->
         settle_cnt == sleep_wake_pkg::OST_CYCLES;
   endproperty
   a_settle: assert property (p_settle) else $error("settle length wrong");
   c_resume: cover property (resume);
   c_vector: cover property (vector_request);
   c_settle: cover property (settle_cnt == 1000);
   c_master_clear_pin: cover property ($fell(master_clear_pin_n));
endmodule
bind sleep_wake_controller sleep_wake_checker #(.PORT_W(PORT_W),
   .WDT_BASE_CYCLES(WDT_BASE_CYCLES)) u_sleep_wake_checker (.clk_sys(clk_sys),
   .reset_n(reset_n), .clk_en(clk_en), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .sleep_op(sleep_op),
   .master_clear_pin_n(master_clear_pin_n), .port_out(port_out), .port_oe(port_oe),
   .osc_driver_en(osc_driver_en), .core_clock_en(core_clock_en),
   .periph_clock_en(periph_clock_en), .core_reset(core_reset), .resume(resume),
   .vector_request(vector_request), .vector_addr(vector_addr),
   .prefetch_next(prefetch_next), .power_down_flag(power_down_flag),
   .timeout_flag(timeout_flag), .watchdog_timeout(watchdog_timeout));

// File: verification/tb_top.sv
/*
 self-checking bench for sleep_wake_controller.
 assumes the bus and sync latency of the design.
*/
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic sleep_op = 1'b0, global_irq_enable = 1'b0, watchdog_fuse_enable = 1'b0;
   logic second_timer_async = 1'b1, adc_private_osc_sel = 1'b1, master_clear_pin_n = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [2:0] osc_mode = 3'h3;
   logic [6:0] irq_flag = 7'h00;
   logic [7:0] port_out_core = 8'h00, port_oe_core = 8'h00, port_out, port_oe;
   logic avs_waitrequest, osc_driver_en, core_clock_en, periph_clock_en, core_reset;
   logic resume, vector_request, prefetch_next, power_down_flag, timeout_flag;
   logic watchdog_timeout;
   logic [12:0] vector_addr;
   int failures = 0, total_checks = 0, resets_seen = 0, resumes = 0, wdt_pulses = 0;
   sleep_wake_controller #(.PORT_W(8), .WDT_BASE_CYCLES(2)) u_sleep_wake_controller (
      .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sleep_op(sleep_op), .watchdog_clear_op(1'b0),
      .global_irq_enable(global_irq_enable), .watchdog_fuse_enable(watchdog_fuse_enable),
      .osc_mode(osc_mode), .second_timer_async(second_timer_async),
      .adc_private_osc_sel(adc_private_osc_sel), .irq_flag(irq_flag),
      .master_clear_pin_n(master_clear_pin_n), .port_out_core(port_out_core),
      .port_oe_core(port_oe_core), .port_out(port_out), .port_oe(port_oe),
      .osc_driver_en(osc_driver_en), .core_clock_en(core_clock_en),
      .periph_clock_en(periph_clock_en), .core_reset(core_reset), .resume(resume),
      .vector_request(vector_request), .vector_addr(vector_addr),
      .prefetch_next(prefetch_next), .power_down_flag(power_down_flag),
      .timeout_flag(timeout_flag), .watchdog_timeout(watchdog_timeout));
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) begin
      resets_seen += (core_reset === 1'b1);
      resumes += (resume === 1'b1);
      wdt_pulses += (watchdog_timeout === 1'b1);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      if (avs_waitrequest !== 1'b0) failures++;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic go_sleep();
      sleep_op <= 1'b1;
      @(posedge clk_sys);
      sleep_op <= 1'b0;
      @(negedge clk_sys);
      check(prefetch_next, 1'b1);
      @(posedge clk_sys);
   endtask
   task automatic wait_wake(input int lim, output int cyc, output logic vec);
      cyc = 0;
      while (cyc < lim) begin
         @(negedge clk_sys);
         cyc++;
         if (resume === 1'b1) break;
      end
      vec = vector_request;
      @(posedge clk_sys);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      bus(1'b0, sleep_wake_pkg::ADDR_CONTROL, 32'h0, q);
      check(q, 32'h08);
      bus(1'b0, sleep_wake_pkg::ADDR_IRQ_ENABLE, 32'h0, q);
      check(q, 32'h00);
      bus(1'b1, sleep_wake_pkg::ADDR_STATUS, 32'h0, q);
      bus(1'b0, sleep_wake_pkg::ADDR_STATUS, 32'h0, q);
      check(q, 32'h03);
      bus(1'b0, 4'h2, 32'h0, q);
      check(q, 32'h00);
      $display("test regs done");
   endtask
   task automatic t_pending();
      logic [31:0] q;
      bus(1'b1, sleep_wake_pkg::ADDR_IRQ_ENABLE, 32'h40, q);
      irq_flag <= 7'h40;
      repeat (6) @(posedge clk_sys);
      go_sleep();
      check({core_clock_en, power_down_flag, timeout_flag}, 3'b111);
      irq_flag <= 7'h00;
      repeat (6) @(posedge clk_sys);
      $display("test pending done");
   endtask
   task automatic t_irq();
      int cyc;
      logic vec;
      logic [31:0] q;
      for (int s = 0; s < sleep_wake_pkg::IRQ_COUNT; s++) begin
         global_irq_enable <= s[0];
         port_out_core <= 8'hA5 ^ 8'(s);
         port_oe_core <= 8'(s);
         bus(1'b1, sleep_wake_pkg::ADDR_IRQ_ENABLE, 32'(1 << s), q);
         go_sleep();
         port_out_core <= 8'h00;
         port_oe_core <= 8'hFF;
         irq_flag <= 7'h7F ^ 7'(1 << s);
         repeat (8) @(negedge clk_sys);
         check({osc_driver_en, power_down_flag, timeout_flag}, 3'b001);
         check({port_out, port_oe}, {8'hA5 ^ 8'(s), 8'(s)});
         check(core_clock_en, 1'b0);
         @(posedge clk_sys);
         irq_flag <= 7'h7F;
         wait_wake(20, cyc, vec);
         check(cyc < 20, 1'b1);
         check(vec, s[0]);
         irq_flag <= 7'h00;
         repeat (6) @(posedge clk_sys);
      end
      $display("test irq done");
   endtask
   task automatic t_qual();
      int cyc;
      logic vec;
      logic [31:0] q;
      for (int s = 0; s < 3; s += 2) begin
         second_timer_async <= 1'b0;
         adc_private_osc_sel <= 1'b0;
         bus(1'b1, sleep_wake_pkg::ADDR_IRQ_ENABLE, 32'(1 << s), q);
         go_sleep();
         irq_flag <= 7'h05;
         repeat (10) @(posedge clk_sys);
         check(core_clock_en, 1'b0);
         second_timer_async <= 1'b1;
         adc_private_osc_sel <= 1'b1;
         wait_wake(20, cyc, vec);
         check(cyc < 20, 1'b1);
         irq_flag <= 7'h00;
         repeat (6) @(posedge clk_sys);
      end
      $display("test qualify done");
   endtask
   task automatic t_wdt();
      int cyc, r0;
      logic vec;
      logic [31:0] q;
      r0 = resets_seen;
      bus(1'b1, sleep_wake_pkg::ADDR_IRQ_ENABLE, 32'h0, q);
      bus(1'b1, sleep_wake_pkg::ADDR_CONTROL, 32'h09, q);
      go_sleep();
      bus(1'b0, sleep_wake_pkg::ADDR_WDT_COUNT, 32'h0, q);
      check(q < 8, 1'b1);
      bus(1'b0, sleep_wake_pkg::ADDR_STATUS, 32'h0, q);
      check(q[4:2], 3'b101);
      wait_wake(100, cyc, vec);
      check({cyc < 100, vec, timeout_flag}, 3'b100);
      check(resets_seen, r0);
      bus(1'b0, sleep_wake_pkg::ADDR_WDT_COUNT, 32'h0, q);
      check(q < 8, 1'b1);
      bus(1'b0, sleep_wake_pkg::ADDR_STATUS, 32'h0, q);
      check(q[6:5], sleep_wake_pkg::CAUSE_WDT);
      bus(1'b1, sleep_wake_pkg::ADDR_CONTROL, 32'h08, q);
      $display("test watchdog done");
   endtask
   task automatic t_settle();
      int cyc, w0;
      logic vec;
      logic [31:0] q;
      osc_mode <= 3'h1;
      watchdog_fuse_enable <= 1'b1;
      bus(1'b1, sleep_wake_pkg::ADDR_IRQ_ENABLE, 32'h40, q);
      bus(1'b0, sleep_wake_pkg::ADDR_STATUS, 32'h0, q);
      check(q[4], 1'b1);
      w0 = wdt_pulses;
      go_sleep();
      irq_flag <= 7'h40;
      wait_wake(1100, cyc, vec);
      check(cyc >= 1024 && cyc <= 1032, 1'b1);
      check(wdt_pulses, w0);
      watchdog_fuse_enable <= 1'b0;
      osc_mode <= 3'h3;
      irq_flag <= 7'h00;
      repeat (6) @(posedge clk_sys);
      $display("test settle done");
   endtask
   task automatic t_master_clear_pin();
      int n = 0, r0;
      logic [31:0] q;
      bus(1'b1, sleep_wake_pkg::ADDR_IRQ_ENABLE, 32'h0, q);
      r0 = resumes;
      go_sleep();
      master_clear_pin_n <= 1'b0;
      while (core_reset !== 1'b1 && n < 10) begin
         @(negedge clk_sys);
         n++;
      end
      repeat (3) @(negedge clk_sys);
      check({n < 10, core_clock_en}, 2'b11);
      check(resumes, r0);
      @(posedge clk_sys);
      master_clear_pin_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      $display("test master_clear_pin done");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // far above the settle wait plus all loops
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      wrap_up();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_pending();
      t_irq();
      t_qual();
      t_wdt();
      t_settle();
      t_master_clear_pin();
      wrap_up();
   end
endmodule
